// [core/imp_top.v]
// Purpose: mode decode and command pulse handling of the inertial subsystem
// Assumes: apb slave, zero wait states; pulse pins asynchronous to pclk
// Notes:   mode discretes and torque controls are software registers
//
// Operation
// - In fine align the inertial error counters are held clear, the radar ones hold, and none take pulses while read counters keep counting.
// - Fine align is entered from inertial reference by activating the fine align electronics and left by deactivating them.
//   The decode enters it from any mode once fine is set with error counter enable, coarse and inertial data clear.
// - Each set pulse stands for one fixed increment of gimbal displacement on both sides.
// - Torque current flows for a time set by the number of set pulses received for that gyro and no longer.
// - Error counter enable as the only discrete gives display attitude error mode.
// - In display attitude error the error counter changes only on computer pulses, with read feedback cut.
// - Display inertial data enables inertial and radar channel error counters under the inertial data discretes.
// - The temperature alarm also goes out to the power and servo assembly for telemetry.
// - Error counter enable together with coarse align gives coarse align mode.
// - No mode discretes gives inertial reference mode.
`timescale 1ns/1ns
`default_nettype none
`include "imp_regs.vh"
module imp_top #(
  parameter PULSE_CYC = `IMP_PULSE_CYC
) (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // command pulses: 3 inertial then 2 radar channels
  input  wire [4:0]  cmd_pos_pulse,
  input  wire [4:0]  cmd_neg_pulse,
  // gimbal angle increments from resolvers
  input  wire [2:0]  gimbal_pos_inc,
  input  wire [2:0]  gimbal_neg_inc,
  // torquing set pulse and temperature alarm
  input  wire        set_pulse,
  input  wire        temp_alarm,
  // outputs
  output reg  [74:0] err_count,
  output wire [2:0]  torque_on,
  output reg         temp_alarm_psa,
  output reg  [2:0]  mode,
  output wire        irq
);
  // ==========================================
  // modes
  localparam [2:0] M_IREF   = 3'd0;
  localparam [2:0] M_COARSE = 3'd1;
  localparam [2:0] M_FINE   = 3'd2;
  localparam [2:0] M_DAE    = 3'd3;
  localparam [2:0] M_DID    = 3'd4;

  reg  [7:0]  ctrl_reg;
  reg  [2:0]  int_stat_reg;
  reg  [2:0]  int_mask_reg;
  reg  [2:0]  mode_next;
  reg  [23:0] sync1_reg;
  reg  [23:0] sync2_reg;
  reg  [23:0] sync3_reg;
  reg  [31:0] rd_next;
  reg         hit_next;
  wire [23:0] edge_ev = sync2_reg & ~sync3_reg;
  wire [4:0]  cpos = edge_ev[4:0];
  wire [4:0]  cneg = edge_ev[9:5];
  wire [2:0]  gpos = edge_ev[12:10];
  wire [2:0]  gneg = edge_ev[15:13];
  wire        sev  = edge_ev[16];
  wire        talm = sync2_reg[17];
  wire        talm_rise = sync2_reg[17] & ~sync3_reg[17];
  wire [74:0] err_w;
  wire [44:0] read_w;
  wire [2:0]  tq_done;
  wire        wr = psel && penable && pwrite;
  wire [1:0]  gsel = ctrl_reg[`IMP_CTRL_GSEL_HI:`IMP_CTRL_GSEL_LO];

  // ==========================================
  // pin synchronisers, edge taken after second stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 24'h000000;
      sync2_reg <= 24'h000000;
      sync3_reg <= 24'h000000;
    end else begin
      sync1_reg <= {6'h00, temp_alarm, set_pulse, gimbal_neg_inc, gimbal_pos_inc,
                    cmd_neg_pulse, cmd_pos_pulse};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg; // one rising edge gives one count
    end
  end

  // ==========================================
  // discrete fields of the control word
  wire        ecen_on   = ctrl_reg[`IMP_CTRL_ECEN];
  wire        coarse_on = ctrl_reg[`IMP_CTRL_COARSE];
  wire        fine_on   = ctrl_reg[`IMP_CTRL_FINE];
  wire        tqen_on   = ctrl_reg[`IMP_CTRL_TQEN];
  wire        did_on    = ctrl_reg[`IMP_CTRL_DID];
  wire        rren_on   = ctrl_reg[`IMP_CTRL_RREN];
  // gyro select only steers set pulses, so it is no mode discrete
  wire        no_other  = !coarse_on && !fine_on && !tqen_on && !did_on && !rren_on;

  // ==========================================
  // mode decode
  always @* begin
    mode_next = M_IREF;
    if (ecen_on && coarse_on) begin
      mode_next = M_COARSE;
    end else if (ecen_on && did_on && rren_on) begin
      mode_next = M_DID;
    end else if (ecen_on && no_other) begin
      mode_next = M_DAE;
    end else if (fine_on && !ecen_on && !coarse_on && !did_on) begin
      // fine align is a submode of inertial reference only
      mode_next = M_FINE;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode           <= M_IREF;
      temp_alarm_psa <= 1'b0;
      err_count      <= 75'h0;
    end else begin
      mode           <= mode_next;
      temp_alarm_psa <= talm;
      err_count      <= err_w;
    end
  end

  // ==========================================
  // per-mode counter permissions
  wire        in_coarse = (mode == M_COARSE);
  wire        in_fine   = (mode == M_FINE);
  wire        in_dae    = (mode == M_DAE);
  wire        in_did    = (mode == M_DID);
  wire        inr_en    = in_coarse || in_dae || in_did;
  // set pulses count only in fine align with torque enabled
  wire        tq_gate   = sev && in_fine && tqen_on;

  // ==========================================
  // error and read counters
  genvar i;
  generate
    for (i = 0; i < 5; i = i + 1) begin : g_err
      wire inr = (i < 3);
      // read feedback nulls the error only in coarse align
      wire fb  = inr && in_coarse;
      wire en  = inr ? inr_en
                     : in_did;
      imp_udcnt #(.W(`IMP_CNT_W)) u_err (
        .pclk      (pclk),
        .presetn   (presetn),
        .clr       (inr && mode == M_FINE),
        .en        (en),
        .up        (cpos[i] || (fb && gneg[i % 3])),
        .dn        (cneg[i] || (fb && gpos[i % 3])),
        .count_reg (err_w[i*15 +: 15])
      );
    end
    for (i = 0; i < 3; i = i + 1) begin : g_read
      // read counters report gimbal increments in every mode
      imp_udcnt #(.W(`IMP_CNT_W)) u_read (
        .pclk      (pclk),
        .presetn   (presetn),
        .clr       (1'b0),
        .en        (1'b1),
        .up        (gpos[i]),
        .dn        (gneg[i]),
        .count_reg (read_w[i*15 +: 15])
      );
      // set pulses steer only to the selected gyro while torque is enabled
      imp_torq #(.PULSE_CYC(PULSE_CYC)) u_torq (
        .pclk     (pclk),
        .presetn  (presetn),
        .add      (tq_gate && gsel == i),
        .on_reg   (torque_on[i]),
        .done_reg (tq_done[i])
      );
    end
  endgenerate

  // ==========================================
  // apb slave, zero wait states
  assign pready = 1'b1;

  always @* begin
    rd_next  = 32'h0;
    hit_next = 1'b1;
    case (paddr)
      `IMP_CTRL_OFF:         rd_next = {24'h0, ctrl_reg};
      `IMP_STATUS_OFF:       rd_next = {25'h0, torque_on, talm, mode};
      `IMP_INT_STAT_OFF:     rd_next = {29'h0, int_stat_reg};
      `IMP_INT_MASK_OFF:     rd_next = {29'h0, int_mask_reg};
      `IMP_ERR_BASE:         rd_next = {17'h0, err_w[14:0]};
      `IMP_ERR_BASE + 8'h04: rd_next = {17'h0, err_w[29:15]};
      `IMP_ERR_BASE + 8'h08: rd_next = {17'h0, err_w[44:30]};
      `IMP_ERR_BASE + 8'h0C: rd_next = {17'h0, err_w[59:45]};
      `IMP_ERR_BASE + 8'h10: rd_next = {17'h0, err_w[74:60]};
      `IMP_READ_BASE:        rd_next = {17'h0, read_w[14:0]};
      `IMP_READ_BASE + 8'h04: rd_next = {17'h0, read_w[29:15]};
      `IMP_READ_BASE + 8'h08: rd_next = {17'h0, read_w[44:30]};
      default:               hit_next = 1'b0;
    endcase
  end

  // read data captured in the setup cycle so it leaves a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h0 : rd_next;
      pslverr <= !hit_next;
    end
  end

  // ==========================================
  // control and interrupt registers; hardware set beats w1c
  wire        wr_ctrl = wr && (paddr == `IMP_CTRL_OFF);
  wire        wr_stat = wr && (paddr == `IMP_INT_STAT_OFF);
  wire        wr_mask = wr && (paddr == `IMP_INT_MASK_OFF);
  wire [2:0]  int_set = {mode != mode_next, |tq_done, talm_rise};
  reg  [7:0]  ctrl_next;
  reg  [2:0]  int_stat_next;
  reg  [2:0]  int_mask_next;

  always @* begin
    ctrl_next     = ctrl_reg;
    int_stat_next = int_stat_reg;
    int_mask_next = int_mask_reg;
    if (wr_ctrl) begin
      ctrl_next = pwdata[7:0];
    end
    if (wr_mask) begin
      int_mask_next = pwdata[2:0];
    end
    if (wr_stat) begin
      int_stat_next = int_stat_reg & ~pwdata[2:0];
    end
    // an event in the clearing cycle stays set so it is never lost
    int_stat_next = int_stat_next | int_set;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= `IMP_CTRL_RST;
      int_stat_reg <= `IMP_INT_RST;
      int_mask_reg <= `IMP_INT_RST;
    end else begin
      ctrl_reg     <= ctrl_next;
      int_stat_reg <= int_stat_next;
      int_mask_reg <= int_mask_next;
    end
  end

  // irq is one discrete, high while any unmasked status bit is set
  assign irq = |(int_stat_reg & int_mask_reg);
endmodule
`default_nettype wire

// [core/imp_regs.vh]
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   included by the mode and pulse control core
`ifndef IMP_REGS_VH
`define IMP_REGS_VH
// ==========================================
// register offsets
`define IMP_CTRL_OFF      8'h00
`define IMP_STATUS_OFF    8'h04
`define IMP_INT_STAT_OFF  8'h08
`define IMP_INT_MASK_OFF  8'h0C
`define IMP_ERR_BASE      8'h10
`define IMP_READ_BASE     8'h24
// ==========================================
// control fields
`define IMP_CTRL_ECEN     0
`define IMP_CTRL_COARSE   1
`define IMP_CTRL_FINE     2
`define IMP_CTRL_TQEN     3
`define IMP_CTRL_GSEL_LO  4
`define IMP_CTRL_GSEL_HI  5
`define IMP_CTRL_DID      6
`define IMP_CTRL_RREN     7
`define IMP_CTRL_RST      8'h30
// ==========================================
// interrupt fields
`define IMP_INT_TEMP      0
`define IMP_INT_TQDONE    1
`define IMP_INT_MODE      2
`define IMP_INT_RST       3'h0
// ==========================================
// counter widths and timing
`define IMP_CNT_W         15
`define IMP_TQ_W          16
`define IMP_CLK_NS        20
`define IMP_PULSE_NS      312500
`define IMP_PULSE_CYC     (`IMP_PULSE_NS / `IMP_CLK_NS)
`endif

// [core/imp_udcnt.v]
// Purpose: up/down counter with clear and enable
// Assumes: up and dn are one-cycle events on pclk
// Notes:   simultaneous up and dn cancel
`timescale 1ns/1ns
`default_nettype none
module imp_udcnt #(
  parameter W = 15
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // control
  input  wire         clr,
  input  wire         en,
  input  wire         up,
  input  wire         dn,
  // value
  output reg  [W-1:0] count_reg
);
  // ==========================================
  // counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= {W{1'b0}};
    end else if (clr) begin
      count_reg <= {W{1'b0}};
    end else if (en && up && !dn) begin
      count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
    end else if (en && dn && !up) begin
      count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// [core/imp_torq.v]
// Purpose: one gyro torque timer, current on while set pulses remain
// Assumes: add is a one-cycle event per received set pulse
// Notes:   each pulse holds the current for one pulse period
`timescale 1ns/1ns
`default_nettype none
`include "imp_regs.vh"
module imp_torq #(
  parameter PULSE_CYC = `IMP_PULSE_CYC
) (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // set pulse
  input  wire add,
  // torque drive
  output reg  on_reg,
  output reg  done_reg
);
  reg  [`IMP_TQ_W-1:0] pend_reg;
  reg  [31:0]          tick_reg;
  wire                 tick_end = on_reg && (tick_reg == PULSE_CYC - 1);
  // ==========================================
  // pending pulse count and period timer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= {`IMP_TQ_W{1'b0}};
      tick_reg <= 32'h0;
      on_reg   <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (add && !tick_end) begin
        pend_reg <= pend_reg + {{(`IMP_TQ_W-1){1'b0}}, 1'b1};
      end else if (tick_end && !add) begin
        pend_reg <= pend_reg - {{(`IMP_TQ_W-1){1'b0}}, 1'b1};
      end
      tick_reg <= (tick_end || !on_reg) ? 32'h0 : tick_reg + 32'h1;
      // current stops exactly when the last pulse period ends
      if (tick_end && !add && pend_reg == {{(`IMP_TQ_W-1){1'b0}}, 1'b1}) begin
        on_reg   <= 1'b0;
        done_reg <= 1'b1;
      end else if (add) begin
        on_reg <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/imp_props.sv]
// Purpose: port checks of mode and pulse handling
// Assumes: PULSE_CYC equals the bound instance
// Notes:   bound into imp_top
`timescale 1ns/1ns
`default_nettype none
module imp_props #(
  parameter PULSE_CYC = 8
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // watched ports
  input wire logic [2:0]  mode,
  input wire logic [74:0] err_count,
  input wire logic [4:0]  cmd_pos_pulse,
  input wire logic [4:0]  cmd_neg_pulse,
  input wire logic [2:0]  torque_on,
  input wire logic        temp_alarm,
  input wire logic        temp_alarm_psa
);
  // ==========================================
  // on_len counts high cycles of gyro 0 current
  logic [15:0] on_len;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) on_len <= 16'h0;
    else on_len <= torque_on[0] ? on_len + 16'h1 : 16'h0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // windows leave room for the three-stage pin synchroniser
  fine_clear_a: assert property ((mode == 3'h2) [*3] |-> err_count[44:0] == 45'h0)
    else $error("error counters not clear in fine align");
  cmd_only_a: assert property ((mode == 3'h3 && !cmd_pos_pulse && !cmd_neg_pulse) [*6] |-> $stable(err_count))
    else $error("error counter moved without a command pulse");
  iref_hold_a: assert property ((mode == 3'h0) [*4] |-> $stable(err_count[44:0]))
    else $error("error counter moved while disabled");
  radar_hold_a: assert property ((mode != 3'h4) [*6] |-> $stable(err_count[74:45]))
    else $error("radar counter moved outside inertial data mode");
  alarm_set_a: assert property (temp_alarm [*4] |-> temp_alarm_psa)
    else $error("alarm not forwarded");
  alarm_clr_a: assert property (!temp_alarm [*4] |-> !temp_alarm_psa)
    else $error("alarm forwarded without cause");
  torque_mode_a: assert property ($rose(torque_on[0]) |-> $past(mode) == 3'h2)
    else $error("torque current outside fine align");
  torque_len_a: assert property ($fell(torque_on[0]) |-> on_len != 16'h0 && on_len % PULSE_CYC == 0)
    else $error("torque time not a whole number of pulses");
  cover property (mode == 3'h2);
  cover property (mode == 3'h4);
  cover property ($rose(torque_on[0]));
endmodule
bind imp_top imp_props #(.PULSE_CYC(PULSE_CYC)) i_imp_props (.pclk(pclk), .presetn(presetn), .mode(mode),
  .err_count(err_count), .cmd_pos_pulse(cmd_pos_pulse), .cmd_neg_pulse(cmd_neg_pulse),
  .torque_on(torque_on), .temp_alarm(temp_alarm), .temp_alarm_psa(temp_alarm_psa));
`default_nettype wire

// [dv/imp_gc_model.sv]
// Purpose: guidance computer side, pulse bursts on the pins
// Assumes: each pulse high 3 cycles then low gap + 1 cycles, gap >= 3
// Notes:   resolver gimbal increments are also made here
`timescale 1ns/1ns
`default_nettype none
module imp_gc_model (
  // clock
  input  wire logic       pclk,
  // pulse pins
  output var  logic [4:0] cmd_pos_pulse,
  output var  logic [4:0] cmd_neg_pulse,
  output var  logic [2:0] gimbal_pos_inc,
  output var  logic [2:0] gimbal_neg_inc,
  output var  logic       set_pulse
);
  initial {cmd_pos_pulse, cmd_neg_pulse, gimbal_pos_inc, gimbal_neg_inc, set_pulse} = 17'h0;
  // kind 0 positive, 1 negative, 2 set pulse, 3 gimbal increment, 4 gimbal decrement
  task automatic burst(input int kind, input int ch, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      case (kind)
        0: cmd_pos_pulse[ch] <= 1'b1;
        1: cmd_neg_pulse[ch] <= 1'b1;
        2: set_pulse <= 1'b1;
        3: gimbal_pos_inc[ch] <= 1'b1;
        default: gimbal_neg_inc[ch] <= 1'b1;
      endcase
      repeat (3) @(posedge pclk);
      {cmd_pos_pulse, cmd_neg_pulse, gimbal_pos_inc, gimbal_neg_inc, set_pulse} <= 17'h0;
      repeat (gap) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// [dv/inertial_mode_pulse_control_test.sv]
// Purpose: self-checking bench of imp_top
// Assumes: interrupt mask bit high lets that bit through
// Notes:   PULSE_CYC shortened to 8
`timescale 1ns/1ns
`default_nettype none
`include "imp_regs.vh"
module inertial_mode_pulse_control_test;
  logic        pclk, presetn, psel, penable, pwrite, temp_alarm;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, set_pulse, temp_alarm_psa, irq;
  wire  [4:0]  cp, cn;
  wire  [2:0]  gp, gn, torque_on, mode;
  wire  [74:0] err_count;
  int          errors, n_tests, n;
  imp_gc_model i_imp_gc_model (.pclk(pclk), .cmd_pos_pulse(cp), .cmd_neg_pulse(cn), .gimbal_pos_inc(gp),
    .gimbal_neg_inc(gn), .set_pulse(set_pulse));
  imp_top #(.PULSE_CYC(8)) i_imp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cmd_pos_pulse(cp), .cmd_neg_pulse(cn), .gimbal_pos_inc(gp), .gimbal_neg_inc(gn),
    .set_pulse(set_pulse), .temp_alarm(temp_alarm), .err_count(err_count), .torque_on(torque_on),
    .temp_alarm_psa(temp_alarm_psa), .mode(mode), .irq(irq));
  // ==========================================
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      errors++;
      wrap_up();
    end
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  // reads compare the low 15 bits that hold every field
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & 32'h7FFF, exp);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // ==========================================
  task automatic t_reset;
    rchk(`IMP_CTRL_OFF, 32'h30);
    chk(mode, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(pslverr, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_dae;
    apb(1'b1, `IMP_CTRL_OFF, 32'h31);
    wt(2);
    chk(mode, 32'h3);
    i_imp_gc_model.burst(0, 0, 5, 3);
    i_imp_gc_model.burst(1, 1, 2, 10);
    i_imp_gc_model.burst(3, 0, 4, 3);
    i_imp_gc_model.burst(4, 2, 1, 3);
    i_imp_gc_model.burst(0, 3, 1, 3);
    wt(8);
    rchk(`IMP_ERR_BASE, 32'h5);
    chk(err_count[14:0], 32'h5);
    rchk(`IMP_ERR_BASE + 8'h04, 32'h7FFE);
    rchk(`IMP_ERR_BASE + 8'h08, 32'h0);
    rchk(`IMP_ERR_BASE + 8'h0C, 32'h0);
    rchk(`IMP_READ_BASE, 32'h4);
    rchk(`IMP_READ_BASE + 8'h08, 32'h7FFF);
    $display("display attitude error test done");
  endtask
  task automatic t_did;
    apb(1'b1, `IMP_CTRL_OFF, 32'hF1);
    wt(2);
    chk(mode, 32'h4);
    i_imp_gc_model.burst(0, 3, 3, 3);
    i_imp_gc_model.burst(1, 4, 1, 3);
    i_imp_gc_model.burst(0, 0, 1, 3);
    wt(8);
    rchk(`IMP_ERR_BASE + 8'h0C, 32'h3);
    rchk(`IMP_ERR_BASE + 8'h10, 32'h7FFF);
    rchk(`IMP_ERR_BASE, 32'h6);
    apb(1'b1, `IMP_CTRL_OFF, 32'h33);
    wt(2);
    chk(mode, 32'h1);
    // coarse align: read feedback drives the inertial error toward zero
    i_imp_gc_model.burst(3, 0, 1, 3);
    i_imp_gc_model.burst(4, 1, 2, 3);
    wt(8);
    rchk(`IMP_ERR_BASE, 32'h5);
    rchk(`IMP_ERR_BASE + 8'h04, 32'h0);
    rchk(`IMP_READ_BASE + 8'h04, 32'h7FFE);
    $display("inertial data and coarse test done");
  endtask
  task automatic t_fine;
    apb(1'b1, `IMP_CTRL_OFF, 32'h34);
    wt(4);
    chk(mode, 32'h2);
    rchk(`IMP_ERR_BASE, 32'h0);
    i_imp_gc_model.burst(0, 0, 2, 3);
    i_imp_gc_model.burst(3, 0, 2, 3);
    wt(8);
    rchk(`IMP_ERR_BASE, 32'h0);
    rchk(`IMP_READ_BASE, 32'h7);
    i_imp_gc_model.burst(2, 0, 2, 3);
    wt(30);
    chk(torque_on, 32'h0);
    apb(1'b1, `IMP_CTRL_OFF, 32'h0C);
    apb(1'b1, `IMP_INT_STAT_OFF, 32'h7);
    apb(1'b1, `IMP_INT_MASK_OFF, 32'h0);
    n = 0;
    fork
      i_imp_gc_model.burst(2, 0, 2, 3);
      begin
        for (int k = 0; k < 50 && torque_on[0] !== 1'b1; k++) @(posedge pclk);
        chk(torque_on, 32'h1);
        while (torque_on[0] === 1'b1 && n < 100) begin
          @(posedge pclk);
          n++;
        end
      end
    join
    chk(n, 32'd16);
    wt(2);
    rchk(`IMP_INT_STAT_OFF, 32'h2);
    chk(irq, 32'h0);
    apb(1'b1, `IMP_INT_MASK_OFF, 32'h2);
    wt(1);
    chk(irq, 32'h1);
    apb(1'b1, `IMP_INT_STAT_OFF, 32'h2);
    wt(1);
    chk(irq, 32'h0);
    rchk(`IMP_INT_STAT_OFF, 32'h0);
    apb(1'b1, `IMP_INT_MASK_OFF, 32'h0);
    apb(1'b1, `IMP_CTRL_OFF, 32'h30);
    wt(2);
    chk(mode, 32'h0);
    $display("fine align test done");
  endtask
  task automatic t_temp;
    apb(1'b1, `IMP_INT_STAT_OFF, 32'h7);
    temp_alarm <= 1'b1;
    wt(5);
    chk(temp_alarm_psa, 32'h1);
    rchk(`IMP_STATUS_OFF, 32'h8);
    rchk(`IMP_INT_STAT_OFF, 32'h1);
    temp_alarm <= 1'b0;
    wt(5);
    chk(temp_alarm_psa, 32'h0);
    $display("temperature alarm test done");
  endtask
  // ==========================================
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    wt(20000);
    errors++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, temp_alarm, paddr, pwdata} = 45'h0;
    wt(2);
    presetn <= 1'b1;
    t_reset();
    t_dae();
    t_did();
    t_fine();
    t_temp();
    wrap_up();
  end
endmodule
`default_nettype wire
